// file: hdl/strap_pkg.sv
/*
 * Shared constants and types for the software strap block: register
 * offsets, field positions, reset values, window and threshold counts.
 * Assumes a 32-bit classic Wishbone master and a 25 MHz system clock.
 */
package strap_pkg;

    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned WINDOW_NS       = 10_000;
    // Longest interval: round down, with no floor of one cycle
    localparam int unsigned WINDOW_CYCLES   = (WINDOW_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned RX_ERR_LIMIT    = 32;
    localparam int unsigned MLT3_LIMIT      = 20;
    localparam int unsigned SNR_LIMIT       = 20;
    localparam int unsigned CFG_RST_CYCLES  = 4;

    localparam logic [7:0]  OFS_STRAP_ONE   = 8'h00;
    localparam logic [7:0]  OFS_STRAP_THREE = 8'h04;
    localparam logic [7:0]  OFS_FLD_STATUS  = 8'h08;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h0c;
    localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h10;
    localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h14;

    localparam int unsigned DONE_BIT        = 15;
    localparam int unsigned DESCR_BIT       = 10;
    localparam int unsigned POL_BIT         = 6;
    localparam int unsigned XOVER_BIT       = 5;
    localparam int unsigned BYPASS_BIT      = 4;
    localparam int unsigned RECEIVE_FAULT_PIN_BIT       = 3;
    localparam int unsigned MLT3_BIT        = 2;
    localparam int unsigned SNR_BIT         = 1;
    localparam int unsigned ENERGY_BIT      = 0;
    localparam int unsigned FLD_STAT_LSB    = 4;

    localparam logic [15:0] STRAP3_MASK     = 16'h047f;
    localparam logic [15:0] STRAP3_RESET    = 16'h0000;

    // Criterion vector index: 4 descrambler, 3 rx error, 2 mlt3, 1 snr, 0 energy
    localparam int unsigned CR_DESCR        = 4;
    localparam int unsigned CR_RECEIVE_FAULT_PIN        = 3;
    localparam int unsigned CR_MLT3         = 2;
    localparam int unsigned CR_SNR          = 1;
    localparam int unsigned CR_ENERGY       = 0;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_s;

    typedef struct packed {
        logic descrambler_loss;
        logic rx_error;
        logic mlt3_violation;
        logic snr_crossing;
        logic energy_loss;
    } fld_event_s;

endpackage : strap_pkg

// file: hdl/strap_cfg.sv
/*
 * Software strap register three with fast link down detection,
 * reached over classic Wishbone. Holds the strap settings, latches
 * them on config done, drives swap and bypass controls, and drops
 * the link when an enabled criterion fires.
 * Assumes event inputs and MAC-side data come from logic on clk_i.
 */
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ns
module strap_cfg
    import strap_pkg::*;
#(
    parameter int unsigned RX_LIMIT   = RX_ERR_LIMIT,
    parameter int unsigned MLT_LIMIT  = MLT3_LIMIT,
    parameter int unsigned SNR_LIM    = SNR_LIMIT
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire wb_req_s     wb_req_i,
    output wb_rsp_s          wb_rsp_o,
    input  wire fld_event_s  event_i,
    input  wire logic [3:0]  mac_txd_i,
    input  wire logic        test_data_in_i,
    input  wire logic [4:0]  rx_symbol_i,
    input  wire logic        rx_decode_error_i,
    input  wire logic        line_transmit_pair_i,
    input  wire logic        line_receive_pair_i,
    input  wire logic        tx_line_bit_i,
    output logic             line_transmit_pair_o,
    output logic             line_receive_pair_o,
    output logic             rx_line_bit_o,
    output logic [4:0]       tx_symbol_o,
    output logic             receive_fault_pin_o,
    output logic             cfg_reset_o,
    output logic             polarity_swap_o,
    output logic             pair_crossover_select_o,
    output logic             port_mirror_o,
    output logic             bypass_4b5b_o,
    output logic             link_drop_o,
    output logic             irq_o
);

    localparam logic [7:0] WIN_LAST = 8'(WINDOW_CYCLES - 1);
    localparam logic [5:0] RX_MAX   = 6'(RX_LIMIT);
    localparam logic [4:0] MLT_MAX  = 5'(MLT_LIMIT);
    localparam logic [4:0] SNR_MAX  = 5'(SNR_LIM);
    localparam logic [2:0] RST_LAST = 3'(CFG_RST_CYCLES - 1);

    typedef struct packed {
        logic        ack;
        logic [31:0] rdat;
        logic [15:0] strap3;
        logic        done;
        logic [15:0] active;
        logic        rst_busy;
        logic [2:0]  rst_cnt;
        logic [7:0]  win_cnt;
        logic [5:0]  cnt_rx;
        logic [4:0]  cnt_mlt;
        logic [4:0]  cnt_snr;
        logic [1:0]  lvl_prev;
        logic [4:0]  fld_stat;
        logic [4:0]  irq_stat;
        logic [4:0]  irq_en;
        logic        drop;
        logic [4:0]  tx_sym;
        logic        rx_fault;
    } state_s;

    state_s st;
    state_s next_st;

    // Merge write data into a 16-bit register under byte enables
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wdat,
                                            input logic [3:0]  sel);
        logic [15:0] res;
        res = old;
        if (sel[0]) begin
            res[7:0] = wdat[7:0];
        end
        if (sel[1]) begin
            res[15:8] = wdat[15:8];
        end
        return res;
    endfunction : merge16

    logic       req;
    logic       wr;
    logic       rd;
    logic       win_end;
    logic [4:0] fire;
    logic [4:0] en;
    logic       pol;
    logic       xover;

    always_comb begin
        req     = wb_req_i.cyc & wb_req_i.stb & ~st.ack;
        wr      = req & wb_req_i.we;
        rd      = req & ~wb_req_i.we;
        win_end = (st.win_cnt == WIN_LAST);
        en      = {st.active[DESCR_BIT], st.active[RECEIVE_FAULT_PIN_BIT], st.active[MLT3_BIT],
                   st.active[SNR_BIT], st.active[ENERGY_BIT]};
        pol     = st.active[POL_BIT];
        xover   = st.active[XOVER_BIT];
        fire    = '0;
        next_st = st;

        // Bus answer one cycle after the request, dropped the cycle after
        next_st.ack  = req;
        next_st.rdat = '0;

        if (wr) begin
            unique case (wb_req_i.adr)
                OFS_STRAP_ONE: begin
                    if (wb_req_i.sel[1] && wb_req_i.dat[DONE_BIT]) begin
                        next_st.done     = 1'b1;
                        next_st.rst_busy = 1'b1;
                        next_st.rst_cnt  = '0;
                        next_st.active   = st.strap3;
                    end
                end
                OFS_STRAP_THREE: begin
                    next_st.strap3 = merge16(st.strap3, wb_req_i.dat, wb_req_i.sel)
                                     & STRAP3_MASK;
                end
                OFS_IRQ_ENABLE: begin
                    if (wb_req_i.sel[0]) begin
                        next_st.irq_en = wb_req_i.dat[4:0];
                    end
                end
                default: begin
                end
            endcase
        end

        if (rd) begin
            unique case (wb_req_i.adr)
                OFS_STRAP_ONE:   next_st.rdat = {16'h0000, st.done, 15'h0000};
                OFS_STRAP_THREE: next_st.rdat = {16'h0000, st.strap3 & STRAP3_MASK};
                OFS_FLD_STATUS:  next_st.rdat = 32'({st.fld_stat, 4'h0});
                OFS_IRQ_STATUS:  next_st.rdat = {27'h0000000, st.irq_stat};
                OFS_IRQ_ENABLE:  next_st.rdat = {27'h0000000, st.irq_en};
                default:         next_st.rdat = '0;
            endcase
        end

        if (st.rst_busy) begin
            next_st.rst_cnt = st.rst_cnt + 3'h1;
            if (st.rst_cnt == RST_LAST) begin
                next_st.rst_busy = 1'b0;
            end
        end

        next_st.win_cnt = win_end ? 8'h00 : st.win_cnt + 8'h01;

        if (event_i.rx_error && en[CR_RECEIVE_FAULT_PIN] && st.cnt_rx != RX_MAX) begin
            next_st.cnt_rx = st.cnt_rx + 6'h01;
            fire[CR_RECEIVE_FAULT_PIN] = (st.cnt_rx + 6'h01 == RX_MAX);
        end
        if (event_i.mlt3_violation && en[CR_MLT3] && st.cnt_mlt != MLT_MAX) begin
            next_st.cnt_mlt = st.cnt_mlt + 5'h01;
            fire[CR_MLT3]   = (st.cnt_mlt + 5'h01 == MLT_MAX);
        end
        if (event_i.snr_crossing && en[CR_SNR] && st.cnt_snr != SNR_MAX) begin
            next_st.cnt_snr = st.cnt_snr + 5'h01;
            fire[CR_SNR]    = (st.cnt_snr + 5'h01 == SNR_MAX);
        end
        if (win_end || st.rst_busy || !en[CR_RECEIVE_FAULT_PIN]) begin
            next_st.cnt_rx = '0;
        end
        if (win_end || st.rst_busy || !en[CR_MLT3]) begin
            next_st.cnt_mlt = '0;
        end
        if (win_end || st.rst_busy || !en[CR_SNR]) begin
            next_st.cnt_snr = '0;
        end

        fire[CR_DESCR]   = en[CR_DESCR] & event_i.descrambler_loss & ~st.lvl_prev[1];
        fire[CR_ENERGY]  = en[CR_ENERGY] & event_i.energy_loss & ~st.lvl_prev[0];
        next_st.lvl_prev = {event_i.descrambler_loss, event_i.energy_loss};
        if (st.rst_busy) begin
            fire = '0;
        end

        next_st.drop = |fire;

        // latch high, cleared by read; set wins
        if (rd && wb_req_i.adr == OFS_FLD_STATUS) begin
            next_st.fld_stat = '0;
        end
        next_st.fld_stat = next_st.fld_stat | fire;

        // Interrupt status: write-one-to-clear, set wins
        if (wr && wb_req_i.adr == OFS_IRQ_CLEAR && wb_req_i.sel[0]) begin
            next_st.irq_stat = st.irq_stat & ~wb_req_i.dat[4:0];
        end
        next_st.irq_stat = next_st.irq_stat | fire;

        next_st.tx_sym   = st.active[BYPASS_BIT] ? {test_data_in_i, mac_txd_i}
                                                 : {1'b0, mac_txd_i};
        next_st.rx_fault = st.active[BYPASS_BIT] ? rx_symbol_i[4] : rx_decode_error_i;

        if (rst_i) begin
            next_st        = '0;
            next_st.strap3 = STRAP3_RESET;
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    always_comb begin
        wb_rsp_o.ack            = st.ack;
        wb_rsp_o.dat            = st.rdat;
        cfg_reset_o             = st.rst_busy;
        polarity_swap_o         = pol;
        pair_crossover_select_o = xover;
        port_mirror_o           = pol & xover;
        bypass_4b5b_o           = st.active[BYPASS_BIT];
        link_drop_o             = st.drop;
        irq_o                   = |(st.irq_stat & st.irq_en);
        tx_symbol_o             = st.tx_sym;
        receive_fault_pin_o     = st.rx_fault;
        line_transmit_pair_o    = xover ? 1'b0 : tx_line_bit_i ^ pol;
        line_receive_pair_o     = xover ? tx_line_bit_i ^ pol : 1'b0;
        rx_line_bit_o           = (xover ? line_transmit_pair_i : line_receive_pair_i) ^ pol;
    end

endmodule : strap_cfg

// file: tb/strap_cfg_checker.sv
/* Port assertions for the strap block.
   Bound to strap_cfg from the testbench top; one clock domain. */
`timescale 1ns/1ns
module strap_cfg_checker
    import strap_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire wb_req_s    wb_req_i,
    input wire wb_rsp_s    wb_rsp_o,
    input wire logic [4:0] rx_symbol_i,
    input wire logic [3:0] mac_txd_i,
    input wire logic       test_data_in_i,
    input wire logic       tx_line_bit_i,
    input wire logic [4:0] tx_symbol_o,
    input wire logic       rx_decode_error_i,
    input wire logic       line_transmit_pair_i,
    input wire logic       line_receive_pair_i,
    input wire logic       line_transmit_pair_o,
    input wire logic       line_receive_pair_o,
    input wire logic       rx_line_bit_o,
    input wire logic       receive_fault_pin_o,
    input wire logic       cfg_reset_o,
    input wire logic       polarity_swap_o,
    input wire logic       pair_crossover_select_o,
    input wire logic       port_mirror_o,
    input wire logic       bypass_4b5b_o,
    input wire logic       link_drop_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_ack_one_cycle: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
        |=> wb_rsp_o.ack) else $error("request not acked next cycle");
    a_idle_data_zero: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0)
        else $error("read data not zero without ack");
    a_cfg_pulse_len:
        assert property ($rose(cfg_reset_o) |-> cfg_reset_o[*4] ##1 !cfg_reset_o)
        else $error("internal reset pulse length wrong");
    a_no_drop_cfg:
        assert property (cfg_reset_o |=> !link_drop_o)
        else $error("link drop during internal reset");
    a_mirror_both_bits:
        assert property (port_mirror_o == (polarity_swap_o && pair_crossover_select_o))
        else $error("mirror not the and of both swaps");
    a_rx_line_swap:
        assert property (rx_line_bit_o == ((pair_crossover_select_o ? line_transmit_pair_i
            : line_receive_pair_i) ^ polarity_swap_o)) else $error("receive bit wrong");
    a_unused_pair:
        assert property (pair_crossover_select_o ? !line_transmit_pair_o : !line_receive_pair_o)
        else $error("transmit bit on wrong pair");
    a_fault_pin_src:
        assert property (!rst_i |=> receive_fault_pin_o == ($past(bypass_4b5b_o) ?
            $past(rx_symbol_i[4]) : $past(rx_decode_error_i))) else $error("fault pin wrong");
    a_tx_symbol_src:
        assert property (!rst_i |=> tx_symbol_o == ($past(bypass_4b5b_o) ?
            {$past(test_data_in_i), $past(mac_txd_i)} : {1'b0, $past(mac_txd_i)}))
        else $error("transmit symbol wrong");
    a_tx_pair_drive:
        assert property ((line_transmit_pair_o | line_receive_pair_o)
            == (tx_line_bit_i ^ polarity_swap_o)) else $error("transmit bit value wrong");
endmodule : strap_cfg_checker

// file: tb/strap_host_model.sv
/* Host processor model: classic Wishbone master for the strap block.
   Assumes one clock and a slave that acks every request. */
`timescale 1ns/1ns
module strap_host_model
    import strap_pkg::*;
(
    input  wire logic    clk_i,
    input  wire wb_rsp_s wb_rsp_i,
    output wb_req_s      wb_req_o
);
    initial wb_req_o = '0;
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h3, dat: dat};
        do @(posedge clk_i); while (wb_rsp_i.ack !== 1'b1);
        // Released address and data lines show the inverse, never a stale value
        wb_req_o <= '{cyc: 1'b0, stb: 1'b0, we: 1'b0, adr: ~adr, sel: 4'h0, dat: ~dat};
    endtask : xfer
    // model is MII only, so bypass is legal
    task automatic configure(input logic [31:0] straps);
        xfer(1'b1, OFS_STRAP_THREE, straps);
        xfer(1'b1, OFS_STRAP_ONE, 32'h8000);
        repeat (8) @(posedge clk_i);
    endtask : configure
endmodule : strap_host_model

// file: tb/test_strap_cfg.sv
/* Testbench for strap_cfg: registers, strap latching, link drop, interrupt.
   Assumes strap_host_model as bus master and the bound checker. */
`timescale 1ns/1ns
module test_strap_cfg
    import strap_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    wb_req_s     wb_req_i;
    wb_rsp_s     wb_rsp_o;
    fld_event_s  event_i = '0;
    logic [3:0]  mac_txd_i;
    logic [4:0]  rx_symbol_i;
    logic [4:0]  tx_symbol_o;
    logic        test_data_in_i, rx_decode_error_i, tx_line_bit_i;
    logic        line_transmit_pair_i, line_receive_pair_i;
    logic        line_transmit_pair_o, line_receive_pair_o, rx_line_bit_o, receive_fault_pin_o;
    logic        cfg_reset_o, polarity_swap_o, pair_crossover_select_o, port_mirror_o;
    logic        bypass_4b5b_o, link_drop_o, irq_o;
    int          errors = 0, n_tests = 0, drops = 0, cyc = 0;
    logic [31:0] exp_q[$];

    always #20 clk_i = ~clk_i;

    strap_cfg #(.RX_LIMIT(8), .MLT_LIMIT(5), .SNR_LIM(5)) dut (
        .clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .event_i, .mac_txd_i, .test_data_in_i,
        .rx_symbol_i, .rx_decode_error_i, .line_transmit_pair_i, .line_receive_pair_i,
        .tx_line_bit_i, .line_transmit_pair_o, .line_receive_pair_o, .rx_line_bit_o,
        .tx_symbol_o, .receive_fault_pin_o, .cfg_reset_o, .polarity_swap_o,
        .pair_crossover_select_o, .port_mirror_o, .bypass_4b5b_o, .link_drop_o, .irq_o);
    strap_host_model host (.clk_i, .wb_rsp_i(wb_rsp_o), .wb_req_o(wb_req_i));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 32'h0);
    endtask : rd
    task automatic pulse(input int i, input int n);
        repeat (n) begin
            @(posedge clk_i);
            event_i <= fld_event_s'(5'h01 << i);
            @(posedge clk_i);
            event_i <= '0;
        end
    endtask : pulse
    task automatic drop_chk(input string nm, input int e);
        repeat (4) @(posedge clk_i);
        chk(nm, e, drops);
    endtask : drop_chk
    // Keeps a burst of events inside one measurement window
    task automatic align;
        @(posedge clk_i);
        while (cyc % 250 != 20) @(posedge clk_i);
    endtask : align
    task automatic complete_run;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    always @(posedge clk_i) begin
        mac_txd_i            <= 4'($urandom);
        test_data_in_i       <= 1'($urandom);
        rx_symbol_i          <= 5'($urandom);
        rx_decode_error_i    <= 1'($urandom);
        line_transmit_pair_i <= 1'($urandom);
        line_receive_pair_i  <= 1'($urandom);
        tx_line_bit_i        <= 1'($urandom);
        cyc <= rst_i ? 0 : cyc + 1;
        if (link_drop_o === 1'b1) drops <= drops + 1;
        if (wb_rsp_o.ack === 1'b1 && wb_req_i.we === 1'b0)
            chk("read data", exp_q.pop_front(), wb_rsp_o.dat);
    end

    initial begin
        logic [31:0] r;
        int          d;
        int          lim;
        void'($urandom(6));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_STRAP_THREE, 32'h0);
        host.xfer(1'b1, OFS_STRAP_THREE, 32'hffff);
        rd(OFS_STRAP_THREE, 32'h047f);
        r = $urandom;
        host.xfer(1'b1, OFS_STRAP_THREE, r);
        rd(OFS_STRAP_THREE, r & 32'h047f);
        rd(8'h20, 32'h0);
        host.xfer(1'b1, OFS_STRAP_THREE, 32'h0060);
        chk("polarity before done", 0, polarity_swap_o);
        host.configure(32'h0060);
        chk("polarity", 1, polarity_swap_o);
        chk("crossover", 1, pair_crossover_select_o);
        chk("mirror", 1, port_mirror_o);
        rd(OFS_STRAP_ONE, 32'h8000);
        host.configure(32'h0030);
        chk("mirror", 0, port_mirror_o);
        chk("bypass", 1, bypass_4b5b_o);
        host.xfer(1'b1, OFS_IRQ_ENABLE, 32'h1f);
        rd(OFS_IRQ_ENABLE, 32'h1f);
        for (int i = 1; i < 4; i++) begin
            lim = (i == 3) ? 8 : 5;
            host.configure(32'h1 << i);
            align();
            d = drops;
            pulse(i, lim - 1);
            drop_chk("below limit", d);
            align();
            pulse(i, 1);
            drop_chk("new window", d);
            pulse(i, lim - 1);
            drop_chk("at limit", d + 1);
            chk("irq", 1, irq_o);
            rd(OFS_FLD_STATUS, 32'h10 << i);
            rd(OFS_IRQ_STATUS, 32'h1 << i);
            host.xfer(1'b1, OFS_IRQ_CLEAR, 32'h1 << i);
            chk("irq cleared", 0, irq_o);
        end
        rd(OFS_FLD_STATUS, 32'h0);
        host.configure(32'h0401);
        host.xfer(1'b1, OFS_IRQ_ENABLE, 32'h0);
        d = drops;
        event_i <= fld_event_s'(5'h10);
        drop_chk("descrambler", d + 1);
        event_i <= fld_event_s'(5'h11);
        drop_chk("energy", d + 2);
        chk("irq masked", 0, irq_o);
        host.xfer(1'b1, OFS_IRQ_ENABLE, 32'h11);
        chk("irq", 1, irq_o);
        rd(OFS_FLD_STATUS, 32'h110);
        event_i <= '0;
        // Rising events inside the internal reset pulse must not drop the link
        host.xfer(1'b1, OFS_STRAP_ONE, 32'h8000);
        event_i <= fld_event_s'(5'h11);
        drop_chk("during cfg reset", d + 2);
        event_i <= '0;
        host.configure(32'h0008);
        event_i <= fld_event_s'(5'h11);
        pulse(2, 5);
        drop_chk("disabled", d + 2);
        complete_run();
    end

    // About six times the expected run
    initial begin
        #400_000;
        errors++;
        complete_run();
    end
endmodule : test_strap_cfg

bind strap_cfg strap_cfg_checker checker_inst (
    .clk_i, .rst_i, .wb_req_i, .wb_rsp_o, .rx_symbol_i, .rx_decode_error_i,
    .line_transmit_pair_i, .line_receive_pair_i, .line_transmit_pair_o,
    .line_receive_pair_o, .rx_line_bit_o, .receive_fault_pin_o, .cfg_reset_o,
    .polarity_swap_o, .pair_crossover_select_o, .port_mirror_o, .bypass_4b5b_o,
    .link_drop_o, .mac_txd_i, .test_data_in_i, .tx_line_bit_i, .tx_symbol_o);
